// ===== rtl/skb_cond.v
// Condition evaluator for skip and conditional branch operations.
// Assumes operand bytes and status flags are stable for the issue cycle.
`timescale 1ns/1ps
`default_nettype none
`include "skb_consts.vh"

module skb_cond (
    input wire [3:0] op,
    input wire [2:0] bit_sel,
    input wire [7:0] reg_value,
    input wire [7:0] io_value,
    input wire [7:0] status_flags,
    output reg taken,
    output reg is_skip,
    output reg legal
);

    // -----------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------
    wire reg_bit = reg_value[bit_sel];
    wire io_bit = io_value[bit_sel];
    wire sel_flag = status_flags[bit_sel];
    wire zf = status_flags[`SKB_FLAG_ZERO];
    wire cf = status_flags[`SKB_FLAG_CARRY];
    wire nf = status_flags[`SKB_FLAG_NEG];

    always @* begin
        taken = 1'b0;
        is_skip = 1'b0;
        legal = 1'b1;
        case (op)
            `SKB_OP_SKIP_IF_REG_BIT_ONE: begin
                is_skip = 1'b1;
                taken = reg_bit;
            end
            `SKB_OP_SKIP_IF_REG_BIT_ZERO: begin
                is_skip = 1'b1;
                taken = ~reg_bit;
            end
            `SKB_OP_SKIP_IF_IO_BIT_ZERO: begin
                is_skip = 1'b1;
                taken = ~io_bit;
            end
            `SKB_OP_SKIP_IF_IO_BIT_ONE: begin
                is_skip = 1'b1;
                taken = io_bit;
            end
            `SKB_OP_JUMP_IF_FLAG_ONE: taken = sel_flag;
            `SKB_OP_JUMP_IF_FLAG_ZERO: taken = ~sel_flag;
            `SKB_OP_JUMP_IF_EQUAL: taken = zf;
            `SKB_OP_JUMP_IF_UNEQUAL: taken = ~zf;
            `SKB_OP_JUMP_IF_CARRY_ONE: taken = cf;
            `SKB_OP_JUMP_IF_LOWER: taken = cf;
            `SKB_OP_JUMP_IF_CARRY_ZERO: taken = ~cf;
            `SKB_OP_JUMP_IF_SAME_OR_HIGHER: taken = ~cf;
            `SKB_OP_JUMP_IF_NEGATIVE: taken = nf;
            `SKB_OP_JUMP_IF_POSITIVE: taken = ~nf;
            default: legal = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// ===== rtl/skb_consts.vh
// Constants of the skip and conditional branch control block.
// Assumes inclusion by bare name from every design file of the block.
`ifndef SKB_CONSTS_VH
`define SKB_CONSTS_VH

// -----------------------------------------------------------------
// Operation codes presented on the issue port
// -----------------------------------------------------------------
`define SKB_OP_NONE 4'h0
`define SKB_OP_SKIP_IF_REG_BIT_ONE 4'h1
`define SKB_OP_SKIP_IF_REG_BIT_ZERO 4'h2
`define SKB_OP_SKIP_IF_IO_BIT_ZERO 4'h3
`define SKB_OP_SKIP_IF_IO_BIT_ONE 4'h4
`define SKB_OP_JUMP_IF_FLAG_ONE 4'h5
`define SKB_OP_JUMP_IF_FLAG_ZERO 4'h6
`define SKB_OP_JUMP_IF_EQUAL 4'h7
`define SKB_OP_JUMP_IF_UNEQUAL 4'h8
`define SKB_OP_JUMP_IF_CARRY_ONE 4'h9
`define SKB_OP_JUMP_IF_CARRY_ZERO 4'ha
`define SKB_OP_JUMP_IF_SAME_OR_HIGHER 4'hb
`define SKB_OP_JUMP_IF_LOWER 4'hc
`define SKB_OP_JUMP_IF_NEGATIVE 4'hd
`define SKB_OP_JUMP_IF_POSITIVE 4'he

// -----------------------------------------------------------------
// Status flags register bit positions
// -----------------------------------------------------------------
`define SKB_FLAG_CARRY 0
`define SKB_FLAG_ZERO 1
`define SKB_FLAG_NEG 2

// -----------------------------------------------------------------
// Cycle counts and program counter steps
// -----------------------------------------------------------------
`define SKB_CYC_NOT_TAKEN 2'h1
`define SKB_CYC_BRANCH_TAKEN 2'h2
`define SKB_CYC_SKIP_ONE_WORD 2'h2
`define SKB_CYC_SKIP_TWO_WORD 2'h3
`define SKB_STEP_SEQ 2'h1
`define SKB_STEP_SKIP_ONE_WORD 2'h2
`define SKB_STEP_SKIP_TWO_WORD 2'h3
`define SKB_OFS_W 7

// -----------------------------------------------------------------
// APB register map (byte addresses) and fields
// -----------------------------------------------------------------
`define SKB_ADDR_W 8
`define SKB_REG_CTRL 8'h00
`define SKB_REG_STATUS 8'h04
`define SKB_REG_LAST_PC 8'h08
`define SKB_REG_EXEC_CNT 8'h0c
`define SKB_REG_TAKEN_CNT 8'h10
`define SKB_CTRL_ENABLE 0
`define SKB_CTRL_CLR_CNT 1
`define SKB_CTRL_RESET 1'h1
`define SKB_ST_BUSY 0
`define SKB_ST_TAKEN 1
`define SKB_ST_ILLEGAL 2
`define SKB_ST_CYC_LO 4

`endif

// ===== rtl/skb_ctrl.v
// Skip and conditional relative branch control of the core: takes one
// operation per issue handshake, holds issue for the operation's cycles,
// then hands the new program counter back. APB slave for control/stats.
// Assumes operands, flags and the two-word hint come from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "skb_consts.vh"

module skb_ctrl #(
    parameter PC_W = 16
) (
    input wire mclk,
    input wire srst,
    input wire [`SKB_ADDR_W-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire issue_valid,
    output wire issue_ready,
    input wire [3:0] issue_op,
    input wire [2:0] issue_bit,
    input wire [`SKB_OFS_W-1:0] issue_ofs,
    input wire [PC_W-1:0] issue_pc,
    input wire next_two_word,
    input wire [7:0] reg_value,
    input wire [7:0] io_value,
    input wire [7:0] status_flags,
    output wire flags_we,
    output reg pc_load,
    output reg [PC_W-1:0] pc_value,
    output reg [1:0] retire_cycles
);

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_HOLD = 1'b1;

    // Sums are kept to PC_W bits; the carry out is dropped on purpose
    function [PC_W-1:0] pc_add;
        input [PC_W-1:0] base;
        input [PC_W-1:0] delta;
        begin
            pc_add = base + delta;
        end
    endfunction

    function addr_hit;
        input [`SKB_ADDR_W-1:0] a;
        begin
            addr_hit = (a == `SKB_REG_CTRL) || (a == `SKB_REG_STATUS) ||
                (a == `SKB_REG_LAST_PC) || (a == `SKB_REG_EXEC_CNT) ||
                (a == `SKB_REG_TAKEN_CNT);
        end
    endfunction

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    reg state_q;
    reg state_d;
    reg [1:0] remain_q;
    reg [1:0] remain_d;
    reg [PC_W-1:0] target_q;
    reg [PC_W-1:0] target_d;
    // Cycle count of the last accepted op, shown in STATUS
    reg [1:0] cyc_q;
    reg [1:0] cyc_d;
    reg enable_q;
    reg last_taken_q;
    reg last_illegal_q;
    reg [31:0] exec_cnt_q;
    reg [31:0] taken_cnt_q;

    wire cond_taken;
    wire cond_skip;
    wire cond_legal;

    skb_cond u_cond (
        .op(issue_op),
        .bit_sel(issue_bit),
        .reg_value(reg_value),
        .io_value(io_value),
        .status_flags(status_flags),
        .taken(cond_taken),
        .is_skip(cond_skip),
        .legal(cond_legal)
    );

    // -----------------------------------------------------------------
    // Issue decision
    // -----------------------------------------------------------------
    // Back-to-back issue is allowed only after single-cycle operations;
    // longer ones hold the issue port so the pipeline sees the stall.
    // Clearing enable only refuses new work; an operation already held
    // still runs to its retire, so the core never loses a hand-back.
    assign issue_ready = enable_q && (state_q == ST_IDLE);
    wire accept = issue_valid && issue_ready;
    wire do_taken = cond_legal && cond_taken;

    // The block has no path into the status flags at all.
    assign flags_we = 1'b0;

    wire [PC_W-1:0] ofs_ext = {{(PC_W-`SKB_OFS_W){issue_ofs[`SKB_OFS_W-1]}}, issue_ofs};
    // Steps are zero-extended from 2-bit constants. Every sum wraps modulo
    // 2^PC_W, so a skip at the top of program memory lands at the bottom.
    wire [PC_W-1:0] step_seq = {{(PC_W-2){1'b0}}, `SKB_STEP_SEQ};
    wire [PC_W-1:0] step_skip1 = {{(PC_W-2){1'b0}}, `SKB_STEP_SKIP_ONE_WORD};
    wire [PC_W-1:0] step_skip2 = {{(PC_W-2){1'b0}}, `SKB_STEP_SKIP_TWO_WORD};

    reg [PC_W-1:0] new_pc;
    reg [1:0] new_cyc;

    always @* begin
        // Illegal codes never set do_taken, so they fall through as a plain
        // one-cycle step to the next word.
        new_pc = pc_add(issue_pc, step_seq);
        new_cyc = `SKB_CYC_NOT_TAKEN;
        if (do_taken && cond_skip) begin
            if (next_two_word) begin
                new_pc = pc_add(issue_pc, step_skip2);
                new_cyc = `SKB_CYC_SKIP_TWO_WORD;
            end else begin
                new_pc = pc_add(issue_pc, step_skip1);
                new_cyc = `SKB_CYC_SKIP_ONE_WORD;
            end
        end else if (do_taken) begin
            // Relative target is current PC plus offset plus one
            new_pc = pc_add(pc_add(issue_pc, ofs_ext), step_seq);
            new_cyc = `SKB_CYC_BRANCH_TAKEN;
        end
    end

    // -----------------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------------
    reg finish;

    always @* begin
        state_d = state_q;
        remain_d = remain_q;
        target_d = target_q;
        cyc_d = cyc_q;
        finish = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    // Target and count are latched here; operands may then move
                    target_d = new_pc;
                    cyc_d = new_cyc;
                    if (new_cyc == `SKB_CYC_NOT_TAKEN) begin
                        finish = 1'b1;
                    end else begin
                        state_d = ST_HOLD;
                        remain_d = new_cyc - 2'h1;
                    end
                end
            end
            ST_HOLD: begin
                // Counts the cycles still owed; the last one retires
                remain_d = remain_q - 2'h1;
                if (remain_q == 2'h1) begin
                    state_d = ST_IDLE;
                    finish = 1'b1;
                end
            end
            default: begin
                // Unreachable with a one-bit state; recovers to idle anyway
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            remain_q <= 2'h0;
            target_q <= {PC_W{1'b0}};
            cyc_q <= 2'h0;
        end else begin
            state_q <= state_d;
            remain_q <= remain_d;
            target_q <= target_d;
            cyc_q <= cyc_d;
        end
    end

    // -----------------------------------------------------------------
    // Program counter hand-back
    // -----------------------------------------------------------------
    always @(posedge mclk) begin
        if (srst) begin
            pc_load <= 1'b0;
            pc_value <= {PC_W{1'b0}};
            retire_cycles <= 2'h0;
        end else begin
            // A one-cycle pulse; pc_value and retire_cycles hold until the
            // next retire so a stalled consumer can still read them.
            pc_load <= finish;
            if (finish) begin
                pc_value <= target_d;
                retire_cycles <= cyc_d;
            end
        end
    end

    // -----------------------------------------------------------------
    // Statistics
    // -----------------------------------------------------------------
    // Both counters wrap at 2^32 and are meant as free-running totals.
    wire apb_access = psel && penable;
    wire wr_access = apb_access && pwrite;
    wire clr_cnt = wr_access && (paddr == `SKB_REG_CTRL) && pwdata[`SKB_CTRL_CLR_CNT];

    // A clear in the same cycle as an accept still counts that operation.
    // The last_* flags change only on accept, so STATUS shows the latest op.
    always @(posedge mclk) begin
        if (srst) begin
            exec_cnt_q <= 32'h0;
            taken_cnt_q <= 32'h0;
            last_taken_q <= 1'b0;
            last_illegal_q <= 1'b0;
        end else begin
            if (accept) begin
                exec_cnt_q <= clr_cnt ? 32'h1 : exec_cnt_q + 32'h1;
                last_taken_q <= do_taken;
                last_illegal_q <= ~cond_legal;
            end else if (clr_cnt) begin
                exec_cnt_q <= 32'h0;
            end
            if (accept && do_taken) begin
                taken_cnt_q <= clr_cnt ? 32'h1 : taken_cnt_q + 32'h1;
            end else if (clr_cnt) begin
                taken_cnt_q <= 32'h0;
            end
        end
    end

    // -----------------------------------------------------------------
    // APB slave
    // -----------------------------------------------------------------
    // Zero wait states: read data is captured in the setup cycle so it
    // comes from a flop while the access phase is open.
    assign pready = 1'b1;
    // Unmapped reads also return zero from rd_mux alongside the error.
    assign pslverr = apb_access && !addr_hit(paddr);

    always @(posedge mclk) begin
        if (srst) begin
            enable_q <= `SKB_CTRL_RESET;
        end else if (wr_access && (paddr == `SKB_REG_CTRL)) begin
            // The clear bit is a strobe and is never stored
            enable_q <= pwdata[`SKB_CTRL_ENABLE];
        end
    end

    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0;
        case (paddr)
            `SKB_REG_CTRL: rd_mux[`SKB_CTRL_ENABLE] = enable_q;
            `SKB_REG_STATUS: begin
                rd_mux[`SKB_ST_BUSY] = (state_q == ST_HOLD);
                rd_mux[`SKB_ST_TAKEN] = last_taken_q;
                rd_mux[`SKB_ST_ILLEGAL] = last_illegal_q;
                rd_mux[`SKB_ST_CYC_LO+1:`SKB_ST_CYC_LO] = cyc_q;
            end
            `SKB_REG_LAST_PC: rd_mux[PC_W-1:0] = target_q;
            `SKB_REG_EXEC_CNT: rd_mux = exec_cnt_q;
            `SKB_REG_TAKEN_CNT: rd_mux = taken_cnt_q;
            default: rd_mux = 32'h0;
        endcase
    end

    always @(posedge mclk) begin
        if (srst) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            // A counter that moves during the access phase reads its setup value
            prdata <= rd_mux;
        end
    end

endmodule

`default_nettype wire

// ===== sim/skb_ctrl_checker.sv
// Checker for skb_ctrl: issue timing, retire values, status flag writes.
// Assumes one clock domain and the constants header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "skb_consts.vh"
module skb_ctrl_checker #(
    parameter PC_W = 16
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic issue_valid,
    input wire logic issue_ready,
    input wire logic [3:0] issue_op,
    input wire logic [2:0] issue_bit,
    input wire logic [`SKB_OFS_W-1:0] issue_ofs,
    input wire logic [PC_W-1:0] issue_pc,
    input wire logic next_two_word,
    input wire logic [7:0] reg_value,
    input wire logic [7:0] io_value,
    input wire logic [7:0] status_flags,
    input wire logic flags_we,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_value,
    input wire logic [1:0] retire_cycles
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    wire logic acc = issue_valid && issue_ready;
    wire logic [PC_W-1:0] ofs_x = {{(PC_W-`SKB_OFS_W){issue_ofs[`SKB_OFS_W-1]}}, issue_ofs};
    wire logic [7:0] sf = status_flags;
    sequence s_nt;
        pc_load && pc_value == $past(issue_pc) + 1'b1 && retire_cycles == `SKB_CYC_NOT_TAKEN;
    endsequence
    // Busy cycles: no early retire and no second accept
    sequence s_hold;
        !pc_load && !issue_ready;
    endsequence
    sequence s_jmp;
        s_hold ##1 pc_load && pc_value == $past(issue_pc, 2) + $past(ofs_x, 2) + 1'b1 && retire_cycles == 2'h2;
    endsequence
    sequence s_sk1;
        s_hold ##1 pc_load && pc_value == $past(issue_pc, 2) + 2'h2 && retire_cycles == 2'h2;
    endsequence
    sequence s_sk2;
        s_hold ##1 s_hold ##1 pc_load && pc_value == $past(issue_pc, 3) + 2'h3 && retire_cycles == 2'h3;
    endsequence
    property p_br(logic h, logic c);
        (acc && h && c |=> s_jmp) and (acc && h && !c |=> s_nt);
    endproperty
    property p_sk(logic h, logic c);
        (acc && h && !c |=> s_nt) and (acc && h && c && !next_two_word |=> s_sk1)
            and (acc && h && c && next_two_word |=> s_sk2);
    endproperty
    a_flags_kept: assert property (flags_we == 1'b0)
        else $error("status flag write strobe raised");
    a_reg_one_skip: assert property (p_sk(issue_op == `SKB_OP_SKIP_IF_REG_BIT_ONE, reg_value[issue_bit]))
        else $error("register bit one skip wrong");
    a_io_zero_skip: assert property (p_sk(issue_op == `SKB_OP_SKIP_IF_IO_BIT_ZERO, !io_value[issue_bit]))
        else $error("io bit zero skip wrong");
    a_io_one_skip: assert property (p_sk(issue_op == `SKB_OP_SKIP_IF_IO_BIT_ONE, io_value[issue_bit]))
        else $error("io bit one skip wrong");
    a_flag_one_jump: assert property (p_br(issue_op == `SKB_OP_JUMP_IF_FLAG_ONE, sf[issue_bit]))
        else $error("flag one jump wrong");
    a_flag_zero_jump: assert property (p_br(issue_op == `SKB_OP_JUMP_IF_FLAG_ZERO, !sf[issue_bit]))
        else $error("flag zero jump wrong");
    a_equal_jump: assert property (p_br(issue_op == `SKB_OP_JUMP_IF_EQUAL, sf[`SKB_FLAG_ZERO]))
        else $error("equal jump wrong");
    a_unequal_jump: assert property (p_br(issue_op == `SKB_OP_JUMP_IF_UNEQUAL, !sf[`SKB_FLAG_ZERO]))
        else $error("unequal jump wrong");
    a_carry_one_jump: assert property (p_br(issue_op == `SKB_OP_JUMP_IF_CARRY_ONE
        || issue_op == `SKB_OP_JUMP_IF_LOWER, sf[`SKB_FLAG_CARRY])) else $error("carry one jump wrong");
    a_carry_zero_jump: assert property (p_br(issue_op == `SKB_OP_JUMP_IF_CARRY_ZERO
        || issue_op == `SKB_OP_JUMP_IF_SAME_OR_HIGHER, !sf[`SKB_FLAG_CARRY])) else $error("carry zero jump wrong");
    a_neg_jump: assert property (p_br(issue_op == `SKB_OP_JUMP_IF_NEGATIVE, sf[`SKB_FLAG_NEG]))
        else $error("negative jump wrong");
    a_pos_jump: assert property (p_br(issue_op == `SKB_OP_JUMP_IF_POSITIVE, !sf[`SKB_FLAG_NEG]))
        else $error("positive jump wrong");
    a_cycles_range: assert property (pc_load |-> retire_cycles != 2'h0)
        else $error("retire cycle count zero");
    a_reg_zero_skip: assert property (p_sk(issue_op == `SKB_OP_SKIP_IF_REG_BIT_ZERO, !reg_value[issue_bit]))
        else $error("register bit zero skip wrong");
    a_illegal_step: assert property (acc && (issue_op == `SKB_OP_NONE || issue_op == 4'hf) |=> s_nt)
        else $error("illegal op did not step by one");
endmodule
bind skb_ctrl skb_ctrl_checker #(.PC_W(PC_W)) u_chk (.mclk(mclk), .srst(srst), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .issue_op(issue_op), .issue_bit(issue_bit), .issue_ofs(issue_ofs),
    .issue_pc(issue_pc), .next_two_word(next_two_word), .reg_value(reg_value), .io_value(io_value),
    .status_flags(status_flags), .flags_we(flags_we), .pc_load(pc_load), .pc_value(pc_value),
    .retire_cycles(retire_cycles));
`default_nettype wire

// ===== sim/skb_ctrl_tb.sv
// Self-checking bench for skb_ctrl: skips, branches and APB registers.
// Assumes the constants header on the include path; 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "skb_consts.vh"
module skb_ctrl_tb;
    localparam int PW = 16;
    logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, issue_valid = 0, next_two_word = 0;
    logic [7:0] paddr = 0, reg_value = 0, io_value = 0, status_flags = 0;
    logic [31:0] pwdata = 0;
    logic [3:0] issue_op = 0;
    logic [2:0] issue_bit = 0;
    logic [6:0] issue_ofs = 0;
    logic [PW-1:0] issue_pc = 0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, issue_ready, flags_we, pc_load;
    wire logic [PW-1:0] pc_value;
    wire logic [1:0] retire_cycles;
    int n_fail = 0, checks = 0;
    always #5 mclk = ~mclk;
    skb_ctrl #(.PC_W(PW)) dut (.mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .issue_valid(issue_valid), .issue_ready(issue_ready), .issue_op(issue_op), .issue_bit(issue_bit),
        .issue_ofs(issue_ofs), .issue_pc(issue_pc), .next_two_word(next_two_word), .reg_value(reg_value),
        .io_value(io_value), .status_flags(status_flags), .flags_we(flags_we), .pc_load(pc_load),
        .pc_value(pc_value), .retire_cycles(retire_cycles));
    // ----
    // Shared tasks
    // ----
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task finish_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic er);
        @(posedge mclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Expected result worked out here from taken/skip; design sees only the operands
    task run(input logic [3:0] op, input logic [2:0] bt, input logic [6:0] k, input logic [PW-1:0] pc,
        input logic two, input logic [7:0] rv, input logic [7:0] iv, input logic [7:0] sf, input logic sk,
        input logic tk);
        logic [PW-1:0] ep;
        int en, n;
        en = !tk ? 1 : (sk && two ? 3 : 2);
        ep = !tk ? pc + 1 : (sk ? pc + en : pc + {{(PW-7){k[6]}}, k} + 1);
        @(posedge mclk);
        issue_valid <= 1;
        issue_op <= op;
        issue_bit <= bt;
        issue_ofs <= k;
        issue_pc <= pc;
        next_two_word <= two;
        reg_value <= rv;
        io_value <= iv;
        status_flags <= sf;
        n = 0;
        do @(posedge mclk); while (issue_ready !== 1'b1);
        issue_valid <= 0;
        n = 0;
        do begin @(posedge mclk); n++; end while (pc_load !== 1'b1 && n < 8);
        chk("pc_value", pc_value, ep);
        chk("cycles", n, en);
        chk("retire_cycles", retire_cycles, en);
        chk("flags_we", flags_we, 0);
    endtask
    // ----
    // Scenarios
    // ----
    task t_skips;
        run(`SKB_OP_SKIP_IF_REG_BIT_ONE, 3, 0, 16'h0100, 0, 8'h08, 0, 0, 1, 1);
        run(`SKB_OP_SKIP_IF_REG_BIT_ONE, 3, 0, 16'hfffe, 1, 8'h08, 0, 0, 1, 1);
        run(`SKB_OP_SKIP_IF_REG_BIT_ONE, 7, 0, 16'h0010, 1, 8'h7f, 0, 0, 1, 0);
        run(`SKB_OP_SKIP_IF_IO_BIT_ZERO, 5, 0, 16'h0200, 0, 0, 8'hdf, 0, 1, 1);
        run(`SKB_OP_SKIP_IF_IO_BIT_ZERO, 5, 0, 16'h0200, 1, 0, 8'h20, 0, 1, 0);
        run(`SKB_OP_SKIP_IF_IO_BIT_ONE, 0, 0, 16'h0300, 1, 0, 8'h01, 0, 1, 1);
        run(`SKB_OP_SKIP_IF_IO_BIT_ONE, 0, 0, 16'h0300, 0, 0, 8'hfe, 0, 1, 0);
        run(`SKB_OP_SKIP_IF_REG_BIT_ZERO, 2, 0, 16'h0400, 1, 8'hfb, 0, 0, 1, 1);
        run(`SKB_OP_SKIP_IF_REG_BIT_ZERO, 2, 0, 16'h0400, 0, 8'h04, 0, 0, 1, 0);
        run(`SKB_OP_NONE, 0, 0, 16'h0500, 1, 8'hff, 8'hff, 8'hff, 1, 0);
    endtask
    task t_flags;
        for (int b = 0; b < 8; b++) begin
            run(`SKB_OP_JUMP_IF_FLAG_ONE, b[2:0], 7'h40, 16'h0100, 0, 0, 0, 8'h01 << b, 0, 1);
            run(`SKB_OP_JUMP_IF_FLAG_ONE, b[2:0], 7'h40, 16'h0100, 0, 0, 0, ~(8'h01 << b), 0, 0);
            run(`SKB_OP_JUMP_IF_FLAG_ZERO, b[2:0], 7'h3f, 16'hffc0, 0, 0, 0, ~(8'h01 << b), 0, 1);
            run(`SKB_OP_JUMP_IF_FLAG_ZERO, b[2:0], 7'h3f, 16'hffc0, 0, 0, 0, 8'h01 << b, 0, 0);
        end
    endtask
    task t_named;
        logic [7:0] tb_ops [8];
        logic [7:0] sf;
        tb_ops = '{{`SKB_OP_JUMP_IF_EQUAL, 1'b1, 3'(`SKB_FLAG_ZERO)},
            {`SKB_OP_JUMP_IF_UNEQUAL, 1'b0, 3'(`SKB_FLAG_ZERO)},
            {`SKB_OP_JUMP_IF_CARRY_ONE, 1'b1, 3'(`SKB_FLAG_CARRY)},
            {`SKB_OP_JUMP_IF_LOWER, 1'b1, 3'(`SKB_FLAG_CARRY)},
            {`SKB_OP_JUMP_IF_CARRY_ZERO, 1'b0, 3'(`SKB_FLAG_CARRY)},
            {`SKB_OP_JUMP_IF_SAME_OR_HIGHER, 1'b0, 3'(`SKB_FLAG_CARRY)},
            {`SKB_OP_JUMP_IF_NEGATIVE, 1'b1, 3'(`SKB_FLAG_NEG)},
            {`SKB_OP_JUMP_IF_POSITIVE, 1'b0, 3'(`SKB_FLAG_NEG)}};
        for (int i = 0; i < 8; i++) begin
            for (int v = 0; v < 2; v++) begin
                sf = 8'h01 << tb_ops[i][2:0];
                if (v == 0) sf = ~sf;
                run(tb_ops[i][7:4], 0, 7'h7f, 16'h0040, 0, 0, 0, sf, 0, v[0] == tb_ops[i][3]);
            end
        end
    endtask
    task t_regs;
        logic [31:0] rd;
        logic er;
        apb(0, `SKB_REG_CTRL, 0, rd, er);
        chk("ctrl reset", rd, 32'h1);
        apb(0, 8'h14, 0, rd, er);
        chk("unmapped err", er, 1);
        chk("unmapped data", rd, 0);
        apb(1, `SKB_REG_CTRL, 0, rd, er);
        @(posedge mclk);
        chk("ready disabled", issue_ready, 0);
        apb(1, `SKB_REG_CTRL, 32'h3, rd, er);
        apb(0, `SKB_REG_EXEC_CNT, 0, rd, er);
        chk("exec cleared", rd, 0);
        run(`SKB_OP_JUMP_IF_EQUAL, 0, 7'h05, 16'h0010, 0, 0, 0, 8'h02, 0, 1);
        apb(0, `SKB_REG_TAKEN_CNT, 0, rd, er);
        chk("taken count", rd, 1);
        apb(0, `SKB_REG_STATUS, 0, rd, er);
        chk("status taken", rd, (32'h1 << `SKB_ST_TAKEN) | (32'(`SKB_CYC_BRANCH_TAKEN) << `SKB_ST_CYC_LO));
        apb(0, `SKB_REG_LAST_PC, 0, rd, er);
        chk("last pc", rd, 32'h0016);
        run(4'hf, 0, 0, 16'h0020, 0, 8'hff, 8'hff, 8'hff, 0, 0);
        apb(0, `SKB_REG_STATUS, 0, rd, er);
        chk("status illegal", rd, (32'h1 << `SKB_ST_ILLEGAL) | (32'(`SKB_CYC_NOT_TAKEN) << `SKB_ST_CYC_LO));
        apb(0, `SKB_REG_EXEC_CNT, 0, rd, er);
        chk("exec count", rd, 2);
    endtask
    initial begin
        #100000;
        n_fail++;
        finish_test;
    end
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 0;
        t_regs;
        t_skips;
        t_flags;
        t_named;
        finish_test;
    end
endmodule
`default_nettype wire
